// ### dv/buck_fault_monitor.sv
`timescale 1ns/10ps
`include "buck_fault_consts.svh"

// ============================================================
// Protection and power-good relations at the ports
module buck_fault_monitor #(
  parameter logic [`CNT_W-1:0] PG_DLY_CYC = `CNT_W'(`PG_DELAY_CYC),
  parameter logic [`CNT_W-1:0] SS_CYC     = `CNT_W'(`SS_RAMP_CYC)
) (
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire buck_fault_pkg::sense_t sense_i,
  input wire buck_fault_pkg::loop_t  loop_i,
  input wire buck_fault_pkg::drive_t drive_o,
  input wire logic                   power_good_pin_oe_o
);
  logic [15:0]       uv_len_ff;
  logic [`CNT_W-1:0] up_cnt_ff;
  logic              stop_w;
  logic              valley_w;
  logic              oob_w;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  assign stop_w   = !sense_i.enable || sense_i.bias_low || sense_i.input_supply_low || sense_i.over_temp;
  assign valley_w = (sense_i.ls_above_limit_set_pin || sense_i.ls_above_clamp) && !sense_i.ls_at_neg_limit
                    && !stop_w && !sense_i.fb_below_uv;
  assign oob_w    = sense_i.fb_above_oob && sense_i.ls_zero_cross && !sense_i.ls_at_neg_limit
                    && !stop_w && !sense_i.fb_below_uv && !loop_i.hs_request;

  // Length of the present undervoltage stretch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !sense_i.fb_below_uv) begin
      uv_len_ff <= 16'h0000;
    end else if (uv_len_ff != 16'hffff) begin
      uv_len_ff <= uv_len_ff + 16'h0001;
    end
  end

  // Cycles since the soft-start node was released
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || drive_o.ss_reset) begin
      up_cnt_ff <= '0;
    end else if (up_cnt_ff != '1) begin
      up_cnt_ff <= up_cnt_ff + 1'b1;
    end
  end

  sequence stopped_s;
    stop_w [*3];
  endsequence
  sequence ov_sink_s;
    sense_i.fb_above_ov && !sense_i.ls_at_neg_limit && loop_i.on_time_done && !stop_w;
  endsequence

  valley_hold_a: assert property (valley_w ##1 (valley_w && drive_o.ls_on) |=> drive_o.ls_on)
    else $error("low-side released above valley limit");
  oob_ccm_a: assert property (oob_w ##1 (oob_w && drive_o.ls_on) |=> drive_o.ls_on)
    else $error("low-side released at zero cross while out of bounds");
  neg_pulse_a: assert property (drive_o.ls_on && sense_i.ls_at_neg_limit && !loop_i.on_time_done && !stop_w
    |-> ##[1:2] (drive_o.hs_on && !drive_o.ls_on))
    else $error("no high-side pulse at negative limit");
  ov_sink_a: assert property ((!power_good_pin_oe_o ##0 ov_sink_s) ##1 ov_sink_s [*3]
    |-> !drive_o.hs_on && drive_o.ls_on)
    else $error("overvoltage did not hold high-side off");
  dis_off_a: assert property (drive_o.discharge_on |-> !drive_o.hs_on && !drive_o.ls_on)
    else $error("switch on during discharge");
  dis_start_a: assert property ($fell(sense_i.enable) && !drive_o.ss_reset && !sense_i.fb_below_discharge
    |-> ##[1:3] drive_o.discharge_on)
    else $error("discharge not entered");
  dis_end_a: assert property (sense_i.fb_below_discharge [*3] |-> !drive_o.discharge_on)
    else $error("discharge kept on below threshold");
  ss_hold_a: assert property (drive_o.ss_reset |-> !drive_o.hs_on && !drive_o.ls_on)
    else $error("switching while soft start held");
  stop_a: assert property (stopped_s |-> drive_o.ss_reset)
    else $error("switching with a stop cause");
  uv_delay_a: assert property ($rose(drive_o.ss_reset) && !stop_w |-> uv_len_ff >= 16'(`UV_DELAY_CYC - 1))
    else $error("shutdown before undervoltage delay");
  pg_delay_a: assert property ($fell(power_good_pin_oe_o)
    |-> up_cnt_ff inside {[SS_CYC + PG_DLY_CYC - 2 : SS_CYC + PG_DLY_CYC + 3]})
    else $error("power-good rose at wrong time");
endmodule

bind buck_fault_supervisor buck_fault_monitor #(.PG_DLY_CYC(PG_DLY_CYC), .SS_CYC(SS_CYC)) u_buck_fault_monitor (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .sense_i(sense_i), .loop_i(loop_i), .drive_o(drive_o),
  .power_good_pin_oe_o(power_good_pin_oe_o));

// ### dv/system_supervisor_model.sv
`timescale 1ns/10ps

// ============================================================
// Host side: drives enable, reads the pulled-up power-good line
module system_supervisor_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Requests from the bench
  input  wire logic       run_i,
  input  wire logic       recycle_i,
  input  wire logic [7:0] off_cycles_i,
  // Power-good pin
  input  wire logic       power_good_pin_o,
  input  wire logic       power_good_pin_oe_o,
  // Enable and sensed line
  output logic            enable_o,
  output logic            pg_level_o
);
  logic [7:0] off_cnt_ff;

  // Open-drain line with pull-up
  assign pg_level_o = power_good_pin_oe_o ? power_good_pin_o : 1'b1;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      off_cnt_ff <= 8'h00;
    end else if (recycle_i) begin
      off_cnt_ff <= off_cycles_i;
    end else if (off_cnt_ff != 8'h00) begin
      off_cnt_ff <= off_cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enable_o <= 1'b0;
    end else begin
      enable_o <= run_i && !recycle_i && (off_cnt_ff == 8'h00);
    end
  end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/10ps
`include "buck_fault_consts.svh"

module tb_top;
  logic                   clk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  buck_fault_pkg::sense_t sns = '0;
  buck_fault_pkg::sense_t sense_w;
  buck_fault_pkg::loop_t  loop_r = '0;
  buck_fault_pkg::drive_t drv;
  logic                   pg_o, pg_oe, pg_level, enable_w;
  logic                   run_r = 1'b0, recycle_r = 1'b0;
  logic [7:0]             s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]             s_axi_bresp, s_axi_rresp, r;
  logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                   s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0]            d;
  int                     failures = 0, checks_done = 0, cyc = 0, n;

  always #10 clk_i = ~clk_i;

  always_comb begin
    sense_w = sns;
    sense_w.enable = enable_w;
  end

  buck_fault_supervisor #(.HICCUP_CYC(20'd200), .PG_DLY_CYC(20'd50), .SS_CYC(20'd300)) u_buck_fault_supervisor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sense_i(sense_w), .loop_i(loop_r), .drive_o(drv),
    .power_good_pin_o(pg_o), .power_good_pin_oe_o(pg_oe),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  system_supervisor_model u_system_supervisor_model (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run_r), .recycle_i(recycle_r), .off_cycles_i(8'h14),
    .power_good_pin_o(pg_o), .power_good_pin_oe_o(pg_oe), .enable_o(enable_w), .pg_level_o(pg_level));

  // ============================================================
  // Bus, compare and closing tasks
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic check_state(input buck_fault_pkg::sup_state_t exp);
    rd(`REG_STATUS, d, r);
    check_word(32'(d[2:0]), 32'(exp));
  endtask

  task automatic wait_pg(input int uv_until);
    n = 0;
    while (pg_level !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
      if (n == uv_until) sns.fb_below_uv <= 1'b0;
    end
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      report_and_stop();
    end
  end

  // ============================================================
  // Scenarios
  initial begin
    tick(10);
    rst_n_i <= 1'b1;
    rd(`REG_CTRL, d, r);
    check_word(d, `CTRL_RESET);
    rd(8'h10, d, r);
    check_word(32'(r), 32'(`RESP_SLVERR));
    wr(8'h10, 32'h0, r);
    check_word(32'(r), 32'(`RESP_SLVERR));
    wr(`REG_CTRL, 32'h3, r);
    rd(`REG_CTRL, d, r);
    check_word(d, 32'h3);
    wr(`REG_CTRL, `CTRL_RESET, r);
    check_word(32'(pg_level), 32'h0);
    sns.fb_ss_done <= 1'b1;
    sns.fb_below_discharge <= 1'b1;
    sns.fb_below_uv <= 1'b1;
    run_r <= 1'b1;
    wait_pg(250);
    check_word(32'(n >= 345 && n <= 360), 32'h1);
    check_state(buck_fault_pkg::ST_RUN);
    sns.fb_below_uv <= 1'b1;
    tick(50);
    sns.fb_below_uv <= 1'b0;
    tick(3);
    check_word(32'(pg_level), 32'h1);
    for (int k = 0; k < 2; k++) begin
      sns.fb_below_uv <= 1'b1;
      tick(3000);
      sns.fb_below_uv <= 1'b0;
      tick(3);
      check_word(32'(pg_level), 32'h0);
      check_state(buck_fault_pkg::ST_RUN);
    end
    sns.fb_below_uv <= 1'b1;
    tick(3450);
    check_state(buck_fault_pkg::ST_HICCUP);
    check_word(32'(drv.ss_reset), 32'h1);
    sns.fb_below_uv <= 1'b0;
    tick(130);
    check_state(buck_fault_pkg::ST_HICCUP);
    tick(20);
    check_state(buck_fault_pkg::ST_SOFT);
    rd(`REG_EVENTS, d, r);
    check_word(32'(d[`EV_UV_SHUTDOWN]), 32'h1);
    tick(400);
    check_word(32'(pg_level), 32'h0);
    sns.fb_below_discharge <= 1'b0;
    recycle_r <= 1'b1;
    tick(1);
    recycle_r <= 1'b0;
    tick(4);
    check_word(32'(drv.discharge_on), 32'h1);
    sns.fb_below_discharge <= 1'b1;
    tick(3);
    check_word(32'(drv.discharge_on), 32'h0);
    wait_pg(0);
    check_word(32'(pg_level), 32'h1);
    for (int i = 7; i < 9; i++) begin
      sns[i] <= 1'b1;
      loop_r.hs_request <= 1'b1;
      tick(3);
      check_word(32'({drv.hs_on, drv.ls_on}), 32'h1);
      sns[i] <= 1'b0;
      tick(3);
      check_word(32'({drv.hs_on, drv.ls_on}), 32'h2);
      loop_r.hs_request <= 1'b0;
      tick(3);
    end
    sns.fb_above_oob <= 1'b1;
    tick(4);
    check_word(32'(drv.force_ccm), 32'h1);
    rd(`REG_STATUS, d, r);
    check_word(32'(d[8]), 32'h0);
    sns.fb_above_oob <= 1'b0;
    tick(3);
    check_word(32'(pg_level), 32'h1);
    loop_r.on_time_done <= 1'b1;
    sns.fb_above_ov <= 1'b1;
    tick(5);
    check_word(32'({drv.hs_on, drv.ls_on}), 32'h1);
    sns.ls_above_limit_set_pin <= 1'b1;
    sns.ls_above_clamp <= 1'b1;
    sns.fb_above_oob <= 1'b1;
    sns.ls_zero_cross <= 1'b1;
    tick(3);
    check_word(32'(drv.ls_on), 32'h1);
    sns <= '{fb_ss_done: 1'b1, fb_below_discharge: 1'b1, fb_above_ov: 1'b1, ls_at_neg_limit: 1'b1, default: 1'b0};
    loop_r.on_time_done <= 1'b0;
    tick(1);
    sns.ls_at_neg_limit <= 1'b0;
    tick(2);
    check_word(32'({drv.hs_on, drv.ls_on}), 32'h2);
    loop_r.on_time_done <= 1'b1;
    tick(3);
    check_word(32'({drv.hs_on, drv.ls_on}), 32'h1);
    rd(`REG_STATUS, d, r);
    check_word(32'(d[8]), 32'h1);
    sns.fb_above_ov <= 1'b0;
    for (int i = 9; i < 12; i++) begin
      sns[i] <= 1'b1;
      tick(4);
      check_word(32'(drv.ss_reset), 32'h1);
      check_state(buck_fault_pkg::ST_OFF);
      sns[i] <= 1'b0;
      tick(4);
      check_state(buck_fault_pkg::ST_SOFT);
    end
    wait_pg(0);
    check_word(32'(pg_level), 32'h1);
    wr(`REG_EVENTS, 32'h1f, r);
    rd(`REG_EVENTS, d, r);
    check_word(32'(d[4:0]), 32'h0);
    report_and_stop();
  end
endmodule

// ### verilog/buck_fault_consts.svh
`ifndef BUCK_FAULT_CONSTS_SVH
`define BUCK_FAULT_CONSTS_SVH

// ============================================================
// Clock and timing
`define CLK_MHZ             50
`define UV_DELAY_US         68
`define PG_GLITCH_US        2
`define HICCUP_SLEEP_US     14000
`define PG_DELAY_US         1060
`define SS_RAMP_US          2000
`define UV_DELAY_CYC        (`UV_DELAY_US * `CLK_MHZ)
`define PG_GLITCH_CYC       (`PG_GLITCH_US * `CLK_MHZ)
`define HICCUP_SLEEP_CYC    (`HICCUP_SLEEP_US * `CLK_MHZ)
`define PG_DELAY_CYC        (`PG_DELAY_US * `CLK_MHZ)
`define SS_RAMP_CYC         (`SS_RAMP_US * `CLK_MHZ)
`define CNT_W               20

// ============================================================
// Register map (byte addresses)
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_EVENTS          8'h08
`define REG_UV_COUNT        8'h0c

// ============================================================
// Fields and reset values
`define CTRL_UV_EN_BIT      0
`define CTRL_CCM_BIT        1
`define CTRL_RESET          32'h0000_0001
`define EV_UV_SHUTDOWN      0
`define EV_OV               1
`define EV_OOB              2
`define EV_PG_LATCH         3
`define EV_DISCHARGE        4
`define EV_W                5

// ============================================================
// Bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ### verilog/buck_fault_pkg.sv
package buck_fault_pkg;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_SOFT     = 3'b001,
    ST_RUN      = 3'b010,
    ST_HICCUP   = 3'b011
  } sup_state_t;

  // Comparator and supply inputs, all synchronous to clk_i
  typedef struct packed {
    logic enable;
    logic bias_low;
    logic input_supply_low;
    logic over_temp;
    logic ls_above_limit_set_pin;
    logic ls_above_clamp;
    logic ls_at_neg_limit;
    logic ls_zero_cross;
    logic fb_below_uv;
    logic fb_above_ov;
    logic fb_above_oob;
    logic fb_ss_done;
    logic fb_below_discharge;
  } sense_t;

  // Loop timing requests
  typedef struct packed {
    logic hs_request;
    logic on_time_done;
  } loop_t;

  // Power-stage commands
  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic discharge_on;
    logic ss_reset;
    logic force_ccm;
  } drive_t;

endpackage

// ### verilog/buck_fault_supervisor.sv
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "buck_fault_consts.svh"

module buck_fault_supervisor #(
  parameter logic [`CNT_W-1:0] HICCUP_CYC = `CNT_W'(`HICCUP_SLEEP_CYC),
  parameter logic [`CNT_W-1:0] PG_DLY_CYC = `CNT_W'(`PG_DELAY_CYC),
  parameter logic [`CNT_W-1:0] SS_CYC     = `CNT_W'(`SS_RAMP_CYC)
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // Comparators and loop
  input  wire buck_fault_pkg::sense_t   sense_i,
  input  wire buck_fault_pkg::loop_t    loop_i,
  // Power stage
  output buck_fault_pkg::drive_t        drive_o,
  // Open-drain power-good pin
  output logic                          power_good_pin_o,
  output logic                          power_good_pin_oe_o,
  // AXI4-Lite write channels
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);

  // ============================================================
  // Declarations
  localparam logic [`CNT_W-1:0] UV_CYC  = `CNT_W'(`UV_DELAY_CYC);
  localparam logic [`CNT_W-1:0] GLT_CYC = `CNT_W'(`PG_GLITCH_CYC);

  buck_fault_pkg::sup_state_t state_ff;
  buck_fault_pkg::sup_state_t nxt_state;
  buck_fault_pkg::drive_t     drive_ff;
  buck_fault_pkg::drive_t     nxt_drive;

  logic [`CNT_W-1:0]  timer_ff;
  logic [`CNT_W-1:0]  uv_cnt_ff;
  logic [`CNT_W-1:0]  pg_cnt_ff;
  logic [`CNT_W-1:0]  glitch_cnt_ff;
  logic               ss_int_done_ff;
  logic               ov_latch_ff;
  logic               neg_pulse_ff;
  logic               pg_good_ff;
  logic               pg_latched_low_ff;
  logic               discharge_ff;
  logic               stop_req;
  logic               valley_hit;
  logic               uv_expired;
  logic               pg_fault;
  logic               switching;
  logic               ccm;
  logic [31:0]        ctrl_ff;
  logic [`EV_W-1:0]   events_ff;
  logic [`EV_W-1:0]   ev_set;
  logic               aw_held_ff;
  logic               w_held_ff;
  logic [7:0]         awaddr_ff;
  logic [31:0]        wdata_ff;
  logic [3:0]         wstrb_ff;
  logic               wr_fire;
  logic [31:0]        rd_word;
  logic               rd_hit;

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Saturating up-counter step
  function automatic logic [`CNT_W-1:0] bump(input logic [`CNT_W-1:0] v);
    return (&v) ? v : v + `CNT_W'(1);
  endfunction

  // ============================================================
  // Fault conditions
  assign stop_req   = !sense_i.enable || sense_i.over_temp || sense_i.input_supply_low
                      || sense_i.bias_low;
  assign valley_hit = sense_i.ls_above_limit_set_pin || sense_i.ls_above_clamp;
  assign uv_expired = (uv_cnt_ff >= UV_CYC - `CNT_W'(1)) && sense_i.fb_below_uv;
  assign pg_fault   = sense_i.fb_below_uv || sense_i.fb_above_ov;
  assign switching  = (state_ff == buck_fault_pkg::ST_SOFT) || (state_ff == buck_fault_pkg::ST_RUN);
  assign ccm        = ctrl_ff[`CTRL_CCM_BIT] || sense_i.fb_above_oob;

  // ============================================================
  // Sequencing state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      buck_fault_pkg::ST_OFF: begin
        if (!stop_req) begin
          nxt_state = buck_fault_pkg::ST_SOFT;
        end
      end
      buck_fault_pkg::ST_SOFT: begin
        if (stop_req) begin
          nxt_state = buck_fault_pkg::ST_OFF;
        end else if (ss_int_done_ff && sense_i.fb_ss_done) begin
          nxt_state = buck_fault_pkg::ST_RUN;
        end
      end
      buck_fault_pkg::ST_RUN: begin
        if (stop_req) begin
          nxt_state = buck_fault_pkg::ST_OFF;
        end else if (uv_expired && ctrl_ff[`CTRL_UV_EN_BIT]) begin
          nxt_state = buck_fault_pkg::ST_HICCUP;
        end
      end
      buck_fault_pkg::ST_HICCUP: begin
        if (stop_req) begin
          nxt_state = buck_fault_pkg::ST_OFF;
        end else if (timer_ff >= HICCUP_CYC - `CNT_W'(1)) begin
          nxt_state = buck_fault_pkg::ST_SOFT;
        end
      end
      default: begin
        nxt_state = buck_fault_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= buck_fault_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ============================================================
  // Soft-start ramp and hiccup sleep timer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || nxt_state != state_ff) begin
      timer_ff       <= '0;
      ss_int_done_ff <= 1'b0;
    end else begin
      timer_ff <= bump(timer_ff);
      if (state_ff == buck_fault_pkg::ST_SOFT && timer_ff >= SS_CYC - `CNT_W'(1)) begin
        ss_int_done_ff <= 1'b1;
      end
    end
  end

  // ============================================================
  // Undervoltage delay counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_ff != buck_fault_pkg::ST_RUN || !sense_i.fb_below_uv) begin
      uv_cnt_ff <= '0;
    end else begin
      uv_cnt_ff <= bump(uv_cnt_ff);
    end
  end

  // ============================================================
  // Overvoltage latch and negative-limit on-time pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !switching) begin
      ov_latch_ff <= 1'b0;
    end else if (state_ff == buck_fault_pkg::ST_RUN && sense_i.fb_above_ov) begin
      ov_latch_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !switching) begin
      neg_pulse_ff <= 1'b0;
    end else if (neg_pulse_ff && loop_i.on_time_done) begin
      neg_pulse_ff <= 1'b0;
    end else if (drive_ff.ls_on && sense_i.ls_at_neg_limit) begin
      neg_pulse_ff <= 1'b1;
    end
  end

  // ============================================================
  // Output discharge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      discharge_ff <= 1'b0;
    end else if (sense_i.fb_below_discharge) begin
      discharge_ff <= 1'b0;
    end else if (stop_req && state_ff != buck_fault_pkg::ST_OFF) begin
      discharge_ff <= 1'b1;
    end
  end

  // ============================================================
  // Switch commands
  always_comb begin
    nxt_drive              = '0;
    nxt_drive.force_ccm    = switching && ccm;
    nxt_drive.ss_reset     = !switching;
    nxt_drive.discharge_on = discharge_ff && !switching;
    if (switching && !stop_req) begin
      if (neg_pulse_ff && !loop_i.on_time_done) begin
        nxt_drive.hs_on = 1'b1;
      end else if (drive_ff.ls_on && sense_i.ls_at_neg_limit) begin
        nxt_drive.hs_on = 1'b1;
      end else if (drive_ff.ls_on && valley_hit) begin
        nxt_drive.ls_on = 1'b1;
      end else if (ov_latch_ff) begin
        nxt_drive.ls_on = 1'b1;
      end else if (loop_i.hs_request) begin
        nxt_drive.hs_on = 1'b1;
      end else begin
        nxt_drive.ls_on = ccm || !sense_i.ls_zero_cross;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drive_ff <= '{hs_on: 1'b0, ls_on: 1'b0, discharge_on: 1'b0, ss_reset: 1'b1, force_ccm: 1'b0};
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign drive_o = drive_ff;

  // ============================================================
  // Power-good
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_ff != buck_fault_pkg::ST_RUN) begin
      pg_cnt_ff <= '0;
    end else begin
      pg_cnt_ff <= bump(pg_cnt_ff);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_ff != buck_fault_pkg::ST_RUN || !pg_fault) begin
      glitch_cnt_ff <= '0;
    end else begin
      glitch_cnt_ff <= bump(glitch_cnt_ff);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !sense_i.enable || sense_i.input_supply_low || sense_i.bias_low) begin
      pg_latched_low_ff <= 1'b0;
    end else if (glitch_cnt_ff >= GLT_CYC - `CNT_W'(1) && pg_fault) begin
      pg_latched_low_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_ff != buck_fault_pkg::ST_RUN || pg_latched_low_ff) begin
      pg_good_ff <= 1'b0;
    end else if (pg_cnt_ff >= PG_DLY_CYC - `CNT_W'(1)) begin
      pg_good_ff <= 1'b1;
    end
  end

  assign power_good_pin_o    = 1'b0;
  assign power_good_pin_oe_o = !pg_good_ff;

  // ============================================================
  // Sticky event flags
  always_comb begin
    ev_set                   = '0;
    ev_set[`EV_UV_SHUTDOWN]  = state_ff == buck_fault_pkg::ST_RUN && nxt_state == buck_fault_pkg::ST_HICCUP;
    ev_set[`EV_OV]           = state_ff == buck_fault_pkg::ST_RUN && sense_i.fb_above_ov;
    ev_set[`EV_OOB]          = switching && sense_i.fb_above_oob;
    ev_set[`EV_PG_LATCH]     = pg_latched_low_ff;
    ev_set[`EV_DISCHARGE]    = discharge_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      events_ff <= '0;
    end else if (wr_fire && awaddr_ff == `REG_EVENTS) begin
      events_ff <= `EV_W'((events_ff & ~merge(32'h0, wdata_ff, wstrb_ff)) | ev_set);
    end else begin
      events_ff <= events_ff | ev_set;
    end
  end

  // ============================================================
  // AXI4-Lite write path
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
  assign wr_fire       = aw_held_ff && w_held_ff && !s_axi_bvalid;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_ff == `REG_CTRL || awaddr_ff == `REG_STATUS || awaddr_ff == `REG_EVENTS
                       || awaddr_ff == `REG_UV_COUNT) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (wr_fire && awaddr_ff == `REG_CTRL) begin
      ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_0003;
    end
  end

  // ============================================================
  // AXI4-Lite read path
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL:     rd_word = ctrl_ff;
      `REG_STATUS:   rd_word = {22'h0, sense_i.fb_above_oob, ov_latch_ff, pg_latched_low_ff, pg_good_ff,
                                discharge_ff, ss_int_done_ff, 1'b0, state_ff};
      `REG_EVENTS:   rd_word = {27'h0, events_ff};
      `REG_UV_COUNT: rd_word = {12'h0, uv_cnt_ff};
      default:       rd_hit  = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
